/* hw/gport_device.sv */
// Device end: request queuing, bus inversion and buffer-full throttles
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module gport_device
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    gport_if.device          LINK,
    input  wire logic        CFG_MODE_30,
    input  wire logic        CFG_RATE_8X,
    input  wire logic        CFG_SIDEBAND,
    input  wire logic        CFG_RBF_PRESENT,
    input  wire logic        CFG_WBF_PRESENT,
    output logic             REQ_VALID,
    input  wire logic        REQ_READY,
    output logic [31:0]      REQ_DATA,
    output logic             REQ_FROM_SB,
    output logic             SB_PULLUP_EN,
    output logic             SB_ISOLATE,
    input  wire logic        TX_VALID,
    input  wire logic        TX_LOWPRI_READ,
    input  wire logic        TX_FAST_WRITE,
    input  wire logic [31:0] TX_DATA,
    output logic             TX_READY,
    output logic             TX_BLOCKED
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0]  clk_s_ff;
    logic        clk_q_ff;
    logic [31:0] ad_s1_ff;
    logic [31:0] ad_s2_ff;
    logic [7:0]  sb_s1_ff;
    logic [7:0]  sb_s2_ff;
    logic [1:0]  pipe_s_ff;
    logic [1:0]  rbf_s_ff;
    logic [1:0]  wbf_s_ff;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            clk_s_ff  <= 2'h0;
            clk_q_ff  <= 1'h0;
            ad_s1_ff  <= gport_pkg::AD_RESET;
            ad_s2_ff  <= gport_pkg::AD_RESET;
            sb_s1_ff  <= gport_pkg::SB_RESET;
            sb_s2_ff  <= gport_pkg::SB_RESET;
            pipe_s_ff <= 2'h3;
            rbf_s_ff  <= 2'h0;
            wbf_s_ff  <= 2'h0;
        end
        else
        begin
            clk_s_ff  <= {clk_s_ff[0], LINK.link_clk};
            clk_q_ff  <= clk_s_ff[1];
            ad_s1_ff  <= LINK.addr_data_bus;
            ad_s2_ff  <= ad_s1_ff;
            sb_s1_ff  <= LINK.sideband_address_bus;
            sb_s2_ff  <= sb_s1_ff;
            pipe_s_ff <= {pipe_s_ff[0], LINK.pin_pipe};
            rbf_s_ff  <= {rbf_s_ff[0], LINK.read_buffer_full};
            wbf_s_ff  <= {wbf_s_ff[0], LINK.write_buffer_full};
        end
    end

    logic link_rise;
    assign link_rise = clk_s_ff[1] & ~clk_q_ff;

    // ----------------------------------------
    // Static configuration latch
    // ----------------------------------------
    logic mech_sb_ff;
    logic mode30_ff;
    logic rate8_ff;
    logic cfg_done_ff;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            mech_sb_ff  <= 1'h0;
            mode30_ff   <= 1'h0;
            rate8_ff    <= 1'h0;
            cfg_done_ff <= 1'h0;
        end
        else if (!cfg_done_ff)
        begin
            mech_sb_ff  <= CFG_SIDEBAND;
            mode30_ff   <= CFG_MODE_30;
            rate8_ff    <= CFG_RATE_8X;
            cfg_done_ff <= 1'h1;
        end
    end

    // Sideband input conditioning
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            SB_PULLUP_EN <= 1'h0;
            SB_ISOLATE   <= 1'h1;
        end
        else
        begin
            SB_PULLUP_EN <= ~mode30_ff & mech_sb_ff;
            SB_ISOLATE   <= ~mode30_ff & ~mech_sb_ff;
        end
    end

    // ----------------------------------------
    // Request capture
    // ----------------------------------------
    logic        pipe_req;
    logic        sb_req;
    logic [31:0] rx_word;
    logic        rx_inv;

    // Pin is inversion flag in 3.0, active-low request in 2.0
    assign rx_inv   = mode30_ff & pipe_s_ff[1];
    assign rx_word  = rx_inv ? {~ad_s2_ff[31:16], ad_s2_ff[15:0]} : ad_s2_ff;
    assign pipe_req = cfg_done_ff & link_rise & ~mode30_ff & ~mech_sb_ff
                      & ~pipe_s_ff[1];
    assign sb_req   = cfg_done_ff & link_rise & mech_sb_ff
                      & (sb_s2_ff != gport_pkg::SB_IDLE);

    // ----------------------------------------
    // Two-entry request buffer
    // ----------------------------------------
    logic [32:0] buf_mem_ff [gport_pkg::BUF_DEPTH];
    logic        wr_ptr_ff;
    logic        rd_ptr_ff;
    logic [1:0]  count_ff;
    logic        buf_push;
    logic        buf_pop;

    assign buf_push  = (pipe_req | sb_req) && (count_ff != 2'h2);
    assign buf_pop   = REQ_VALID & REQ_READY;
    assign REQ_VALID = (count_ff != 2'h0);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            wr_ptr_ff <= 1'h0;
            rd_ptr_ff <= 1'h0;
            count_ff  <= 2'h0;
        end
        else
        begin
            if (buf_push)
                wr_ptr_ff <= ~wr_ptr_ff;
            if (buf_pop)
                rd_ptr_ff <= ~rd_ptr_ff;
            count_ff <= count_ff + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (buf_push)
            buf_mem_ff[wr_ptr_ff] <= sb_req ? {1'b1, 24'h00_0000, sb_s2_ff}
                                            : {1'b0, rx_word};
    end

    assign REQ_DATA    = REQ_VALID ? buf_mem_ff[rd_ptr_ff][31:0] : gport_pkg::AD_RESET;
    assign REQ_FROM_SB = REQ_VALID & buf_mem_ff[rd_ptr_ff][32];

    // ----------------------------------------
    // Transmit with throttles
    // ----------------------------------------
    logic rbf_eff;
    logic wbf_eff;
    logic rbf_cyc_ff;
    logic wbf_cyc_ff;
    logic blocked;
    logic tx_inv;
    logic [31:0] ad_out_ff;
    logic        ad_oe_ff;
    logic        inv_out_ff;

    assign rbf_eff = CFG_RBF_PRESENT & rbf_s_ff[1];
    assign wbf_eff = CFG_WBF_PRESENT & wbf_s_ff[1];

    // Full flags held from the cycle start
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            rbf_cyc_ff <= 1'h0;
            wbf_cyc_ff <= 1'h0;
        end
        else if (link_rise)
        begin
            rbf_cyc_ff <= rbf_eff;
            wbf_cyc_ff <= wbf_eff;
        end
    end

    assign blocked    = (TX_LOWPRI_READ & rbf_cyc_ff)
                      | (TX_FAST_WRITE & wbf_cyc_ff);
    assign TX_BLOCKED = TX_VALID & blocked;
    assign TX_READY   = cfg_done_ff & link_rise & ~blocked;

    // Inversion in 3.0 at 8x only, when more than half the upper bits are ones
    assign tx_inv = mode30_ff & rate8_ff & ($countones(TX_DATA[31:16]) > 8);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            ad_out_ff  <= gport_pkg::AD_RESET;
            ad_oe_ff   <= 1'h0;
            inv_out_ff <= 1'h0;
        end
        else if (link_rise)
        begin
            ad_oe_ff   <= TX_VALID & TX_READY;
            ad_out_ff  <= tx_inv ? {~TX_DATA[31:16], TX_DATA[15:0]} : TX_DATA;
            inv_out_ff <= TX_VALID & TX_READY & tx_inv;
        end
    end

    assign LINK.ad_d      = ad_out_ff;
    assign LINK.ad_d_oe   = ad_oe_ff;
    assign LINK.pipe_d    = inv_out_ff;
    assign LINK.pipe_d_oe = ad_oe_ff & mode30_ff;

endmodule

/* hw/gport_if.sv */
// Interface joining the graphics port device end and master end
`timescale 1ns/1ps
interface gport_if;
    logic        link_clk;
    logic [31:0] ad_m;
    logic        ad_m_oe;
    logic [31:0] ad_d;
    logic        ad_d_oe;
    logic        pipe_m;
    logic        pipe_m_oe;
    logic        pipe_d;
    logic        pipe_d_oe;
    logic [7:0]  sideband_address_bus;
    logic        read_buffer_full;
    logic        write_buffer_full;
    logic        upper_first_strobe;

    // Resolved shared wires
    logic [31:0] addr_data_bus;
    logic        pin_pipe;
    assign addr_data_bus = ad_m_oe ? ad_m : (ad_d_oe ? ad_d : 32'h0000_0000);
    assign pin_pipe      = pipe_m_oe ? pipe_m : (pipe_d_oe ? pipe_d : 1'h1);

    modport device
    (
        input  link_clk,
        input  addr_data_bus,
        output ad_d,
        output ad_d_oe,
        input  pin_pipe,
        output pipe_d,
        output pipe_d_oe,
        input  sideband_address_bus,
        input  read_buffer_full,
        input  write_buffer_full,
        input  upper_first_strobe
    );

    modport master
    (
        output link_clk,
        input  addr_data_bus,
        input  ad_d_oe,
        output ad_m,
        output ad_m_oe,
        input  pin_pipe,
        output pipe_m,
        output pipe_m_oe,
        output sideband_address_bus,
        output read_buffer_full,
        output write_buffer_full,
        output upper_first_strobe
    );
endinterface

/* hw/gport_master.sv */
// Master end: drives link clock, queues requests, reports buffer full
`timescale 1ns/1ps
module gport_master
(
    input  wire logic        MCLK,
    input  wire logic        RST,
    gport_if.master          LINK,
    input  wire logic        CFG_MODE_30,
    input  wire logic        CFG_SIDEBAND,
    input  wire logic        REQ_VALID,
    input  wire logic [31:0] REQ_ADDR,
    input  wire logic [7:0]  REQ_SB,
    output logic             REQ_READY,
    input  wire logic        RD_FULL,
    input  wire logic        WR_FULL,
    output logic             RX_VALID,
    output logic [31:0]      RX_DATA
);

    // ----------------------------------------
    // Link clock divider
    // ----------------------------------------
    logic [2:0] div_ff;
    logic       lclk_ff;
    logic       fall_en;

    assign fall_en = lclk_ff && (div_ff == gport_pkg::LINK_HALF - 3'h1);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            div_ff  <= 3'h0;
            lclk_ff <= 1'h0;
        end
        else if (div_ff == gport_pkg::LINK_HALF - 3'h1)
        begin
            div_ff  <= 3'h0;
            lclk_ff <= ~lclk_ff;
        end
        else
            div_ff <= div_ff + 3'h1;
    end

    // Static mechanism choice after reset
    logic mech_sb_ff;
    logic mode30_ff;
    logic cfg_done_ff;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            mech_sb_ff  <= 1'h0;
            mode30_ff   <= 1'h0;
            cfg_done_ff <= 1'h0;
        end
        else if (!cfg_done_ff)
        begin
            mech_sb_ff  <= CFG_SIDEBAND & ~CFG_MODE_30 | CFG_MODE_30;
            mode30_ff   <= CFG_MODE_30;
            cfg_done_ff <= 1'h1;
        end
    end

    // ----------------------------------------
    // Request drive, changed on link falling edge
    // ----------------------------------------
    logic [31:0] ad_ff;
    logic        ad_oe_ff;
    logic        pipe_n_ff;
    logic        pipe_oe_ff;
    logic [7:0]  sb_ff;
    logic        rbf_ff;
    logic        wbf_ff;

    assign REQ_READY = cfg_done_ff & fall_en;

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            ad_ff      <= gport_pkg::AD_RESET;
            ad_oe_ff   <= 1'h0;
            pipe_n_ff  <= 1'h1;
            pipe_oe_ff <= 1'h0;
            sb_ff      <= gport_pkg::SB_IDLE;
            rbf_ff     <= 1'h0;
            wbf_ff     <= 1'h0;
        end
        else if (fall_en)
        begin
            rbf_ff <= RD_FULL;
            wbf_ff <= WR_FULL;
            if (mech_sb_ff)
            begin
                sb_ff      <= (REQ_VALID & cfg_done_ff) ? REQ_SB : gport_pkg::SB_IDLE;
                ad_oe_ff   <= 1'h0;
                pipe_oe_ff <= 1'h0;
            end
            else
            begin
                ad_ff      <= REQ_ADDR;
                ad_oe_ff   <= REQ_VALID & cfg_done_ff;
                pipe_n_ff  <= ~(REQ_VALID & cfg_done_ff);
                pipe_oe_ff <= cfg_done_ff;
            end
        end
    end

    assign LINK.link_clk             = lclk_ff;
    assign LINK.ad_m                 = ad_ff;
    assign LINK.ad_m_oe              = ad_oe_ff;
    assign LINK.pipe_m               = pipe_n_ff;
    assign LINK.pipe_m_oe            = pipe_oe_ff;
    assign LINK.sideband_address_bus = sb_ff;
    assign LINK.read_buffer_full     = rbf_ff;
    assign LINK.write_buffer_full    = wbf_ff;
    assign LINK.upper_first_strobe   = lclk_ff;

    // ----------------------------------------
    // Receive from device with inversion flag
    // ----------------------------------------
    logic [31:0] rx_ff;
    logic        rx_v_ff;
    logic        rise_en;

    assign rise_en = ~lclk_ff && (div_ff == gport_pkg::LINK_HALF - 3'h1);

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            rx_ff   <= gport_pkg::AD_RESET;
            rx_v_ff <= 1'h0;
        end
        else
        begin
            rx_v_ff <= 1'h0;
            if (rise_en && LINK.ad_d_oe && !ad_oe_ff)
            begin
                rx_v_ff <= 1'h1;
                rx_ff   <= (mode30_ff & LINK.pin_pipe)
                           ? {~LINK.addr_data_bus[31:16], LINK.addr_data_bus[15:0]}
                           : LINK.addr_data_bus;
            end
        end
    end

    assign RX_VALID = rx_v_ff;
    assign RX_DATA  = rx_ff;

endmodule

/* hw/gport_pkg.sv */
// Shared constants and types for the graphics port request flow
package gport_pkg;

    // Signalling modes
    typedef enum logic
    {
        SIG_V20 = 1'b0,
        SIG_V30 = 1'b1
    } sig_mode_type;

    // Data rates
    typedef enum logic
    {
        RATE_4X = 1'b0,
        RATE_8X = 1'b1
    } rate_type;

    // Queuing mechanism
    typedef enum logic
    {
        QUEUE_PIPE     = 1'b0,
        QUEUE_SIDEBAND = 1'b1
    } queue_mech_type;

    // Widths
    localparam int AD_W   = 32;
    localparam int HALF_W = 16;
    localparam int SB_W   = 8;

    // Reset values
    localparam logic [31:0] AD_RESET  = 32'h0000_0000;
    localparam logic [7:0]  SB_RESET  = 8'h00;
    localparam logic [7:0]  SB_IDLE   = 8'hff;

    // Link clock divider: half period of the master's link clock in MCLK cycles
    localparam logic [2:0]  LINK_HALF = 3'h4;

    // Two-entry buffer depth
    localparam int BUF_DEPTH = 2;

endpackage

/* verif/gport_link_chk.sv */
// Checker on the link wires between the two port ends
`timescale 1ns/1ps
module gport_link_chk
(
    input wire logic        MCLK,
    input wire logic        RST,
    input wire logic        link_clk,
    input wire logic [31:0] ad_m,
    input wire logic        ad_m_oe,
    input wire logic        ad_d_oe,
    input wire logic        pipe_m,
    input wire logic        pipe_m_oe,
    input wire logic        pipe_d_oe,
    input wire logic        pin_pipe,
    input wire logic        upper_first_strobe
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    property p_ad_excl; !(ad_m_oe && ad_d_oe); endproperty
    a_ad_excl: assert property (p_ad_excl) else $error("both ends drive data bus");
    property p_pipe_excl; !(pipe_m_oe && pipe_d_oe); endproperty
    a_pipe_excl: assert property (p_pipe_excl) else $error("both ends drive pipe pin");
    property p_link_hi; $rose(link_clk) |-> link_clk [*4] ##1 !link_clk; endproperty
    a_link_hi: assert property (p_link_hi) else $error("link clock high phase wrong");
    property p_link_lo; $fell(link_clk) |-> !link_clk [*4] ##1 link_clk; endproperty
    a_link_lo: assert property (p_link_lo) else $error("link clock low phase wrong");
    property p_strobe; upper_first_strobe == link_clk; endproperty
    a_strobe: assert property (p_strobe) else $error("first strobe off link clock");
    property p_reset_idle; $past(RST) |-> pin_pipe; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("pipe pin busy after reset");
    property p_ad_hold; link_clk && $past(link_clk) && ad_m_oe |-> $stable(ad_m); endproperty
    a_ad_hold: assert property (p_ad_hold) else $error("request word moved in cycle");
    property p_pipe_hold; link_clk && $past(link_clk) && pipe_m_oe |-> $stable(pipe_m); endproperty
    a_pipe_hold: assert property (p_pipe_hold) else $error("pipe pin moved in cycle");
endmodule

/* verif/graphics_port_request_flow_tb.sv */
// Testbench: both port ends joined, results checked against queue models
`timescale 1ns/1ps
module graphics_port_request_flow_tb;
    logic        mclk, rst, cfg_30, cfg_8x, cfg_sb, rbf_on, wbf_on, sbm;
    logic        d_vld, d_rdy, d_sb, pu_en, iso, tx_vld, tx_lp, tx_fw, tx_rdy, tx_blk;
    logic        m_vld, m_rdy, rd_full, wr_full, rx_vld;
    logic [31:0] d_data, tx_data, m_addr, rx_data;
    logic [7:0]  m_sb;
    logic [31:0] rq[$];
    logic [31:0] xq[$];
    int          checks;
    int          miscompares;

    gport_if link ();
    gport_device gport_device_i (.MCLK(mclk), .RST(rst), .LINK(link), .CFG_MODE_30(cfg_30),
        .CFG_RATE_8X(cfg_8x), .CFG_SIDEBAND(cfg_sb), .CFG_RBF_PRESENT(rbf_on),
        .CFG_WBF_PRESENT(wbf_on), .REQ_VALID(d_vld), .REQ_READY(d_rdy), .REQ_DATA(d_data),
        .REQ_FROM_SB(d_sb), .SB_PULLUP_EN(pu_en), .SB_ISOLATE(iso), .TX_VALID(tx_vld),
        .TX_LOWPRI_READ(tx_lp), .TX_FAST_WRITE(tx_fw), .TX_DATA(tx_data), .TX_READY(tx_rdy),
        .TX_BLOCKED(tx_blk));
    gport_master gport_master_i (.MCLK(mclk), .RST(rst), .LINK(link), .CFG_MODE_30(cfg_30),
        .CFG_SIDEBAND(cfg_sb), .REQ_VALID(m_vld), .REQ_ADDR(m_addr), .REQ_SB(m_sb),
        .REQ_READY(m_rdy), .RD_FULL(rd_full), .WR_FULL(wr_full), .RX_VALID(rx_vld),
        .RX_DATA(rx_data));
    gport_link_chk gport_link_chk_i (.MCLK(mclk), .RST(rst), .link_clk(link.link_clk),
        .ad_m(link.ad_m), .ad_m_oe(link.ad_m_oe), .ad_d_oe(link.ad_d_oe),
        .pipe_m(link.pipe_m), .pipe_m_oe(link.pipe_m_oe), .pipe_d_oe(link.pipe_d_oe),
        .pin_pipe(link.pin_pipe), .upper_first_strobe(link.upper_first_strobe));

    always #20 mclk = ~mclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic test_done;
        $display("Checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic tmo(input int n);
        if (n >= 400)
        begin
            miscompares++;
            $display("ERROR wait expected ready seen none");
            test_done;
        end
    endtask

    task automatic start(input logic m30, r8, sb, rb, wb);
        cfg_30 <= m30;
        cfg_8x <= r8;
        cfg_sb <= sb;
        rbf_on <= rb;
        wbf_on <= wb;
        sbm = sb;
        rst <= 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic req(input logic [31:0] a, input logic [7:0] b);
        int n;
        m_vld <= 1'b1;
        m_addr <= a;
        m_sb <= b;
        n = 0;
        do @(posedge mclk); while (m_rdy !== 1'b1 && ++n < 400);
        tmo(n);
        rq.push_back(sbm ? {24'h000000, b} : a);
    endtask

    task automatic tx(input logic lp, fw, input logic [31:0] d);
        int   n;
        logic inv;
        tx_vld <= 1'b1;
        tx_lp <= lp;
        tx_fw <= fw;
        tx_data <= d;
        n = 0;
        do @(posedge mclk); while (tx_rdy !== 1'b1 && ++n < 400);
        tmo(n);
        xq.push_back(d);
        tx_vld <= 1'b0;
        @(posedge mclk);
        inv = cfg_8x && ($countones(d[31:16]) > 8);
        cmp("dbi_flag", {31'h0, inv}, {31'h0, link.pin_pipe});
        cmp("ad_wire", {inv ? ~d[31:16] : d[31:16], d[15:0]}, link.addr_data_bus);
    endtask

    // Throttle levels set, then one return that must stall when blocked
    task automatic thr(input logic rb, wb, lp, fw, e);
        int n;
        rd_full <= rb;
        wr_full <= wb;
        repeat (24) @(posedge mclk);
        if (e)
        begin
            tx_vld <= 1'b1;
            tx_lp <= lp;
            tx_fw <= fw;
            n = 0;
            repeat (24)
            begin
                @(posedge mclk);
                n += (tx_rdy === 1'b1);
            end
            cmp("tx_stall", 32'h0, n);
            cmp("tx_blocked", 32'h1, {31'h0, tx_blk});
            rd_full <= 1'b0;
            wr_full <= 1'b0;
        end
        tx(lp, fw, $urandom);
    endtask

    task automatic fin(input string nm);
        m_vld <= 1'b0;
        repeat (64) @(posedge mclk);
        cmp("req_left", 32'h0, rq.size());
        cmp("rx_left", 32'h0, xq.size());
        $display("Test %s done", nm);
    endtask

    // ------------------------------------------------------------
    // Result monitors
    // ------------------------------------------------------------
    always @(posedge mclk)
    begin
        d_rdy <= ($urandom_range(3) != 0);
        if (d_vld && d_rdy)
        begin
            cmp("req_data", rq.pop_front(), sbm ? {24'h000000, d_data[7:0]} : d_data);
            cmp("req_from_sb", {31'h0, sbm}, {31'h0, d_sb});
        end
        if (rx_vld)
            cmp("rx_data", xq.pop_front(), rx_data);
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        rst = 1'b1;
        {cfg_30, cfg_8x, cfg_sb, rbf_on, wbf_on, sbm} = 6'h00;
        {d_rdy, tx_vld, tx_lp, tx_fw, m_vld, rd_full, wr_full} = 7'h00;
        tx_data = 32'h0000_0000;
        m_addr = 32'h0000_0000;
        m_sb = 8'hff;
        checks = 0;
        miscompares = 0;
        void'($urandom(32'h9e55));
        start(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        cmp("sb_isolate", 32'h1, {31'h0, iso});
        cmp("sb_pullup", 32'h0, {31'h0, pu_en});
        repeat (8) req($urandom, 8'($urandom));
        fin("pipelined");
        start(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
        cfg_sb <= 1'b0;
        cmp("sb_isolate", 32'h0, {31'h0, iso});
        cmp("sb_pullup", 32'h1, {31'h0, pu_en});
        req($urandom, 8'h00);
        repeat (6) req($urandom, 8'($urandom_range(254)));
        fin("sideband");
        start(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        tx(1'b0, 1'b0, 32'hffff_0000);
        tx(1'b0, 1'b0, 32'h0000_ffff);
        repeat (4) tx(1'b0, 1'b0, $urandom);
        thr(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        thr(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        thr(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        fin("inversion 8x");
        start(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        tx(1'b0, 1'b0, 32'hffff_ffff);
        thr(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        thr(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        fin("plain 4x");
        test_done;
    end
endmodule
